// ### hdl/pmp_pkg.sv
// Constants, types and shared link functions of the parallel MAC/PHY port.
// Assumes a single 10 MHz clk; link clocks are scaled to bench rates.
package pmp_pkg;

   typedef enum logic [1:0] {PMP_GMII, PMP_MII, PMP_RGMII} pmp_mode_t;
   typedef enum logic [1:0] {PMP_S10, PMP_S100, PMP_S1000} pmp_speed_t;

   // ==========================================================
   // Rates and dividers
   localparam int PMP_F1000_KHZ = 125000;
   localparam int PMP_F100_KHZ  = 25000;
   localparam int PMP_F10_KHZ   = 2500;
   localparam int PMP_CLK_NS    = 100;
   // Bench period of the fastest link clock; slower rates keep the ratio
   localparam int PMP_LINK_NS   = 800;
   localparam int PMP_DIV_1000  = PMP_LINK_NS / PMP_CLK_NS;
   localparam int PMP_DIV_100   = PMP_DIV_1000 * PMP_F1000_KHZ / PMP_F100_KHZ;
   localparam int PMP_DIV_10    = PMP_DIV_1000 * PMP_F1000_KHZ / PMP_F10_KHZ;
   localparam int PMP_PHW       = 9;
   localparam logic [PMP_PHW-1:0] PMP_PH_RST = 9'h000;

   // ==========================================================
   // State carried by both ends
   typedef struct packed {
      logic       c;
      logic [3:0] hi;
      logic [3:0] lo;
      logic       ctl;
      logic       en;
   } pmp_lsmp_t;

   typedef struct packed {
      logic [3:0] lo;
      logic [3:0] hi;
      logic       ctl;
      logic       dv;
      logic       mhi;
      logic [7:0] cur;
      logic       cer;
   } pmp_lnch_t;

   typedef struct packed {
      logic       nh;
      logic [3:0] lo;
      logic       c1;
      logic       v;
      logic [7:0] d;
      logic       e;
   } pmp_cap_t;

   // ==========================================================
   // Functions
   function automatic logic [PMP_PHW-1:0] pmp_div(pmp_speed_t s);
      unique case (s)
         PMP_S10:  pmp_div = PMP_PHW'(PMP_DIV_10);
         PMP_S100: pmp_div = PMP_PHW'(PMP_DIV_100);
         default:  pmp_div = PMP_PHW'(PMP_DIV_1000);
      endcase
   endfunction : pmp_div

   function automatic logic pmp_legal(pmp_mode_t m, pmp_speed_t s);
      unique case (m)
         PMP_GMII:  pmp_legal = (s == PMP_S1000);
         PMP_MII:   pmp_legal = (s == PMP_S10) || (s == PMP_S100);
         PMP_RGMII: pmp_legal = (s != 2'h3);
         default:   pmp_legal = 1'b0;
      endcase
   endfunction : pmp_legal

   // Cycle in which a new byte may be taken by the launcher
   function automatic logic pmp_slot(pmp_mode_t m, logic rise, logic fall,
                                     logic mhi);
      pmp_slot = (m == PMP_RGMII) ? fall : (rise && !mhi);
   endfunction : pmp_slot

   // Transmitter side of one link direction; pins change on edges
   function automatic pmp_lnch_t pmp_launch(pmp_lnch_t s, pmp_mode_t m,
                                            logic rise, logic fall,
                                            logic pop, logic [7:0] d,
                                            logic e);
      pmp_lnch_t n;
      n = s;
      if (pmp_slot(m, rise, fall, s.mhi))
      begin
         n.dv  = pop;
         n.cur = pop ? d : 8'h00;
         n.cer = pop && e;
         n.lo  = n.cur[3:0];
         n.hi  = (m == PMP_GMII) ? n.cur[7:4] : 4'h0;
         n.mhi = pop && (m == PMP_MII);
         n.ctl = (m == PMP_RGMII) ? pop : (pop && e);
      end
      else if (rise && (m == PMP_RGMII || s.mhi))
      begin
         n.lo  = s.cur[7:4];
         n.mhi = 1'b0;
         if (m == PMP_RGMII)
            n.ctl = s.dv ^ s.cer;
      end
      return n;
   endfunction : pmp_launch

   // Receiver side; lo/hi/ctl/en are the values held just before the edge
   function automatic pmp_cap_t pmp_cap(pmp_cap_t s, pmp_mode_t m,
                                        logic rise, logic fall,
                                        logic [3:0] lo, logic [3:0] hi,
                                        logic ctl, logic en);
      pmp_cap_t n;
      n   = s;
      n.v = 1'b0;
      unique case (m)
         PMP_GMII:
            if (rise && en)
            begin
               n.v = 1'b1;
               n.d = {hi, lo};
               n.e = ctl;
            end
         PMP_MII:
            if (rise)
            begin
               if (!en)
                  n.nh = 1'b0;
               else if (!s.nh)
               begin
                  n.nh = 1'b1;
                  n.lo = lo;
                  n.c1 = ctl;
               end
               else
               begin
                  n.nh = 1'b0;
                  n.v  = 1'b1;
                  n.d  = {lo, s.lo};
                  n.e  = s.c1 || ctl;
               end
            end
         PMP_RGMII:
            if (rise)
            begin
               n.lo = lo;
               n.c1 = ctl;
            end
            else if (fall && s.c1)
            begin
               n.v = 1'b1;
               n.d = {lo, s.lo};
               n.e = s.c1 ^ ctl;
            end
         default: n.nh = 1'b0;
      endcase
      return n;
   endfunction : pmp_cap

endpackage : pmp_pkg

// ### hdl/pmp_if.sv
// Pin bundle between the PHY end and the MAC end of the port.
// Assumes both ends run on their own clocks; pins are plain levels.
`timescale 1ns/1ps
interface pmp_if;
   logic       rx_clk;
   logic [3:0] rxd_lo;
   logic [3:0] rxd_hi;
   logic       rx_er_ctl;
   logic       rx_dv;
   logic       crs;
   logic       col;
   logic       mii_tx_clk;
   logic       gtx_clk;
   logic [3:0] txd_lo;
   logic [3:0] txd_hi;
   logic       tx_er_ctl;
   logic       tx_en;

   modport phy (
      output rx_clk, rxd_lo, rxd_hi, rx_er_ctl, rx_dv, crs, col, mii_tx_clk,
      input  gtx_clk, txd_lo, txd_hi, tx_er_ctl, tx_en
   );
   modport mac (
      input  rx_clk, rxd_lo, rxd_hi, rx_er_ctl, rx_dv, crs, col, mii_tx_clk,
      output gtx_clk, txd_lo, txd_hi, tx_er_ctl, tx_en
   );
endinterface : pmp_if

// ### hdl/pmp_buf.sv
// Small valid/ready buffer held in flip-flops.
// Assumes both sides on clk; out_data is the head entry's register.
`timescale 1ns/1ps
module pmp_buf #(
   parameter int W     = 9,
   parameter int DEPTH = 2
) (
   // Clock and reset
   input  logic         clk,
   input  logic         resetn,
   // Filling side
   input  logic         in_valid,
   input  logic [W-1:0] in_data,
   output logic         in_ready,
   // Draining side
   output logic         out_valid,
   output logic [W-1:0] out_data,
   input  logic         out_ready
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0]           wp;
      logic [AW-1:0]           rp;
      logic [CW-1:0]           cnt;
   } pmp_buf_st_t;

   pmp_buf_st_t st_r;
   pmp_buf_st_t st_nxt;
   logic        push;
   logic        pull;

   function automatic logic [AW-1:0] pmp_inc(logic [AW-1:0] p);
      return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
   endfunction : pmp_inc

   assign in_ready  = (st_r.cnt != CW'(DEPTH));
   assign out_valid = (st_r.cnt != '0);
   assign out_data  = st_r.mem[st_r.rp];

   always_comb
   begin
      push   = in_valid && in_ready;
      pull   = out_valid && out_ready;
      st_nxt = st_r;
      if (push)
      begin
         st_nxt.mem[st_r.wp] = in_data;
         st_nxt.wp           = pmp_inc(st_r.wp);
      end
      if (pull)
         st_nxt.rp = pmp_inc(st_r.rp);
      if (push && !pull)
         st_nxt.cnt = CW'(st_r.cnt + 1'b1);
      else if (pull && !push)
         st_nxt.cnt = CW'(st_r.cnt - 1'b1);
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end
endmodule : pmp_buf

// ### hdl/pmp_phy.sv
// PHY end of the parallel MAC port: GMII, MII and RGMII.
// Assumes decoded media bytes arrive on a valid/ready stream on clk,
// and that mode and speed are set before link_up rises.
`timescale 1ns/1ps
module pmp_phy #(
   parameter int BUF_DEPTH = 2
) (
   // Clock and reset
   input  logic                clk,
   input  logic                resetn,
   // Configuration
   input  pmp_pkg::pmp_mode_t  mode,
   input  pmp_pkg::pmp_speed_t speed,
   input  logic                full_dup,
   input  logic                link_up,
   output logic                cfg_ok,
   // Media receive stream
   input  logic                med_valid,
   input  logic [7:0]          med_data,
   input  logic                med_err,
   output logic                med_ready,
   input  logic                carrier,
   input  logic                collision,
   // Media transmit stream
   output logic                tx_valid,
   output logic [7:0]          tx_data,
   output logic                tx_err,
   // Link pins
   pmp_if.phy                  lnk
);
   // ==========================================================
   // State
   typedef struct packed {
      logic [pmp_pkg::PMP_PHW-1:0] ph;
      logic                        rclk;
      logic                        tclk;
      pmp_pkg::pmp_lnch_t          l;
      logic                        rdv;
      logic                        crs;
      logic                        col;
      pmp_pkg::pmp_lsmp_t          s1;
      pmp_pkg::pmp_lsmp_t          s2;
      pmp_pkg::pmp_lsmp_t          s3;
      pmp_pkg::pmp_cap_t           c;
   } pmp_phy_st_t;

   pmp_phy_st_t                 st_r;
   pmp_phy_st_t                 st_nxt;
   logic [pmp_pkg::PMP_PHW-1:0] div;
   logic                        ok;
   logic                        rise;
   logic                        fall;
   logic                        trise;
   logic                        tfall;
   logic                        pop;
   logic                        b_valid;
   logic [8:0]                  b_data;
   logic                        half_dup;
   logic                        sdr;

   // ==========================================================
   // Receive buffer
   // Two entries let the media source run one byte ahead of the link
   pmp_buf #(
      .W     (9),
      .DEPTH (BUF_DEPTH)
   ) u_rxbuf (
      .clk       (clk),
      .resetn    (resetn),
      .in_valid  (med_valid),
      .in_data   ({med_err, med_data}),
      .in_ready  (med_ready),
      .out_valid (b_valid),
      .out_data  (b_data),
      .out_ready (pop)
   );

   // ==========================================================
   // Next state
   always_comb
   begin
      st_nxt   = st_r;
      div      = pmp_pkg::pmp_div(speed);
      ok       = link_up && pmp_pkg::pmp_legal(mode, speed);
      half_dup = !full_dup;
      sdr      = (mode != pmp_pkg::PMP_RGMII);

      // Recovered receive clock divider
      if (!ok)
         st_nxt.ph = pmp_pkg::PMP_PH_RST;
      else if (st_r.ph >= div - 9'h001)
         st_nxt.ph = pmp_pkg::PMP_PH_RST;
      else
         st_nxt.ph = 9'(st_r.ph + 9'h001);
      rise = ok && (st_nxt.ph == (div >> 1));
      fall = ok && (st_nxt.ph == pmp_pkg::PMP_PH_RST)
             && (st_r.ph != pmp_pkg::PMP_PH_RST);
      st_nxt.rclk = ok && (st_nxt.ph >= (div >> 1));
      // MII transmit clock runs at the receive rate
      st_nxt.tclk = st_nxt.rclk && (mode == pmp_pkg::PMP_MII);

      // Receive launch: pins change together with the clock edge
      pop = b_valid && pmp_pkg::pmp_slot(mode, rise, fall, st_r.l.mhi);
      if (ok)
         st_nxt.l = pmp_pkg::pmp_launch(st_r.l, mode, rise, fall, pop,
                                        b_data[7:0], b_data[8]);
      else
         st_nxt.l = '0;
      st_nxt.rdv = st_nxt.l.dv && sdr;
      st_nxt.crs = ok && sdr && half_dup && carrier;
      st_nxt.col = ok && sdr && half_dup && collision;

      // Transmit pins: two-stage synchroniser, third stage for edges
      st_nxt.s1 = {(mode == pmp_pkg::PMP_MII) ? st_r.tclk : lnk.gtx_clk,
                   lnk.txd_hi, lnk.txd_lo, lnk.tx_er_ctl, lnk.tx_en};
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      trise     = ok && st_r.s2.c && !st_r.s3.c;
      tfall     = ok && !st_r.s2.c && st_r.s3.c;

      // Capture uses the values held just before the detected edge
      if (ok)
         st_nxt.c = pmp_pkg::pmp_cap(st_r.c, mode, trise, tfall,
                                     st_r.s3.lo, st_r.s3.hi,
                                     st_r.s3.ctl, st_r.s3.en);
      else
         st_nxt.c = '0;
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   // ==========================================================
   // Outputs
   assign lnk.rx_clk     = st_r.rclk;
   assign lnk.rxd_lo     = st_r.l.lo;
   assign lnk.rxd_hi     = st_r.l.hi;
   assign lnk.rx_er_ctl  = st_r.l.ctl;
   assign lnk.rx_dv      = st_r.rdv;
   assign lnk.crs        = st_r.crs;
   assign lnk.col        = st_r.col;
   assign lnk.mii_tx_clk = st_r.tclk;
   assign tx_valid       = st_r.c.v;
   assign tx_data        = st_r.c.d;
   assign tx_err         = st_r.c.e;
   assign cfg_ok         = ok;
endmodule : pmp_phy

// ### hdl/pmp_mac.sv
// MAC end of the parallel port: drives the transmit side, takes receive.
// Assumes mode and speed match the PHY; no stall possible on receive.
`timescale 1ns/1ps
module pmp_mac (
   // Clock and reset
   input  logic                clk,
   input  logic                resetn,
   // Configuration
   input  pmp_pkg::pmp_mode_t  mode,
   input  pmp_pkg::pmp_speed_t speed,
   // Transmit stream from the user
   input  logic                tx_valid,
   input  logic [7:0]          tx_data,
   input  logic                tx_err,
   output logic                tx_ready,
   // Receive stream to the user
   output logic                rx_valid,
   output logic [7:0]          rx_data,
   output logic                rx_err,
   output logic                crs_o,
   output logic                col_o,
   // Link pins
   pmp_if.mac                  lnk
);
   typedef struct packed {
      logic [pmp_pkg::PMP_PHW-1:0] ph;
      logic                        gclk;
      pmp_pkg::pmp_lnch_t          l;
      logic                        ten;
      pmp_pkg::pmp_lsmp_t          s1;
      pmp_pkg::pmp_lsmp_t          s2;
      pmp_pkg::pmp_lsmp_t          s3;
      logic [2:0]                  x1;
      logic [2:0]                  x2;
      logic [2:0]                  x3;
      pmp_pkg::pmp_cap_t           c;
   } pmp_mac_st_t;

   pmp_mac_st_t                 st_r;
   pmp_mac_st_t                 st_nxt;
   logic [pmp_pkg::PMP_PHW-1:0] div;
   logic                        ok;
   logic                        mii;
   logic                        lrise;
   logic                        lfall;
   logic                        rrise;
   logic                        rfall;

   // ==========================================================
   // Next state
   always_comb
   begin
      st_nxt = st_r;
      div    = pmp_pkg::pmp_div(speed);
      ok     = pmp_pkg::pmp_legal(mode, speed);
      mii    = (mode == pmp_pkg::PMP_MII);

      if (!ok || mii || st_r.ph >= div - 9'h001)
         st_nxt.ph = pmp_pkg::PMP_PH_RST;
      else
         st_nxt.ph = 9'(st_r.ph + 9'h001);
      st_nxt.gclk = ok && !mii && (st_nxt.ph >= (div >> 1));

      // Sync of PHY pins; x holds {mii clock, col, crs}
      st_nxt.s1 = {lnk.rx_clk, lnk.rxd_hi, lnk.rxd_lo, lnk.rx_er_ctl,
                   lnk.rx_dv};
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      st_nxt.x1 = {lnk.mii_tx_clk, lnk.col, lnk.crs};
      st_nxt.x2 = st_r.x1;
      st_nxt.x3 = st_r.x2;

      // MII follows the PHY clock; otherwise the own divider
      if (mii)
      begin
         lrise = ok && st_r.x2[2] && !st_r.x3[2];
         lfall = 1'b0;
      end
      else
      begin
         lrise = ok && (st_nxt.ph == (div >> 1));
         lfall = ok && (st_nxt.ph == pmp_pkg::PMP_PH_RST)
                 && (st_r.ph != pmp_pkg::PMP_PH_RST);
      end
      tx_ready = ok && pmp_pkg::pmp_slot(mode, lrise, lfall, st_r.l.mhi);
      if (ok)
         st_nxt.l = pmp_pkg::pmp_launch(st_r.l, mode, lrise, lfall,
                                        tx_ready && tx_valid,
                                        tx_data, tx_err);
      else
         st_nxt.l = '0;
      st_nxt.ten = st_nxt.l.dv && (mode != pmp_pkg::PMP_RGMII);

      rrise = ok && st_r.s2.c && !st_r.s3.c;
      rfall = ok && !st_r.s2.c && st_r.s3.c;
      if (ok)
         st_nxt.c = pmp_pkg::pmp_cap(st_r.c, mode, rrise, rfall,
                                     st_r.s3.lo, st_r.s3.hi,
                                     st_r.s3.ctl, st_r.s3.en);
      else
         st_nxt.c = '0;
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   // ==========================================================
   // Outputs
   assign lnk.gtx_clk   = st_r.gclk;
   assign lnk.txd_lo    = st_r.l.lo;
   assign lnk.txd_hi    = st_r.l.hi;
   assign lnk.tx_er_ctl = st_r.l.ctl;
   assign lnk.tx_en     = st_r.ten;
   assign rx_valid      = st_r.c.v;
   assign rx_data       = st_r.c.d;
   assign rx_err        = st_r.c.e;
   assign crs_o         = st_r.x2[0];
   assign col_o         = st_r.x2[1];
endmodule : pmp_mac

// ### bench/pmp_chk.sv
// Pin-level checks between the PHY and MAC ends of the port.
// Assumes pins sampled on clk; link clocks come from the two ends.
`timescale 1ns/1ps
module pmp_chk (
   // Clock and reset
   input logic       clk,
   input logic       resetn,
   // Receive pins
   input logic       rx_clk,
   input logic [3:0] rxd_lo,
   input logic [3:0] rxd_hi,
   input logic       rx_er_ctl,
   input logic       rx_dv,
   // Transmit pins
   input logic       mii_tx_clk,
   input logic       gtx_clk,
   input logic [3:0] txd_lo,
   input logic [3:0] txd_hi,
   input logic       tx_er_ctl,
   input logic       tx_en
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);

   // ==========================================
   // Receive side
   rx_lo_edge_a:
      assert property ($changed(rxd_lo) |-> $changed(rx_clk))
      else $error("rxd_lo moved off an rx_clk edge");
   rx_hi_rise_a:
      assert property ($changed(rxd_hi) |-> $rose(rx_clk))
      else $error("rxd_hi moved off an rx_clk rise");
   rx_dv_rise_a:
      assert property ($changed(rx_dv) |-> $rose(rx_clk))
      else $error("rx_dv moved off an rx_clk rise");
   rx_ctl_edge_a:
      assert property ($changed(rx_er_ctl) |-> $changed(rx_clk))
      else $error("rx_er_ctl moved off an rx_clk edge");
   rx_clk_high_a:
      assert property ($rose(rx_clk) |-> rx_clk[*4])
      else $error("rx_clk high phase too short");

   // ==========================================
   // Transmit side
   mii_clk_low_a:
      assert property ($fell(mii_tx_clk) |-> !mii_tx_clk[*4])
      else $error("mii_tx_clk low phase too short");
   tx_hi_rise_a:
      assert property ($changed(txd_hi) |-> $rose(gtx_clk))
      else $error("txd_hi moved off a gtx_clk rise");
   tx_en_edge_a:
      assert property ($changed(tx_en) |->
                       $changed(gtx_clk) || mii_tx_clk)
      else $error("tx_en moved off a transmit clock edge");
   tx_lo_edge_a:
      assert property (($changed(txd_lo) || $changed(tx_er_ctl)) |->
                       ($changed(gtx_clk) || mii_tx_clk))
      else $error("txd_lo or tx_er_ctl moved off a clock edge");

   cov_rx_dv: cover property ($rose(rx_dv));
   cov_tx_en: cover property ($rose(tx_en));
   cov_rgmii: cover property ($fell(gtx_clk) && tx_er_ctl);
   cov_mii:   cover property ($rose(mii_tx_clk) ##[1:8] $rose(tx_en));
endmodule : pmp_chk

// ### bench/tb.sv
// Both ends joined back to back; streams checked end to end.
// Assumes the ends make their own link clocks from clk.
`timescale 1ns/1ps
module tb;
   logic                clk, resetn, full_dup, link_up, carrier;
   logic                collision, cfg_ok, med_valid, med_err, med_ready;
   logic                p_tx_valid, p_tx_err, m_tx_valid, m_tx_err;
   logic                m_tx_ready, m_rx_valid, m_rx_err, crs_o, col_o;
   logic [7:0]          med_data, p_tx_data, m_tx_data, m_rx_data;
   pmp_pkg::pmp_mode_t  mode;
   pmp_pkg::pmp_speed_t speed;
   logic [8:0]          rxq[$], txq[$];
   int                  fail_count, checks_done, stalls;

   pmp_if u_pmp_if ();
   pmp_phy #(.BUF_DEPTH(2)) u_pmp_phy (.clk(clk), .resetn(resetn),
      .mode(mode), .speed(speed), .full_dup(full_dup), .link_up(link_up),
      .cfg_ok(cfg_ok), .med_valid(med_valid), .med_data(med_data),
      .med_err(med_err), .med_ready(med_ready), .carrier(carrier),
      .collision(collision), .tx_valid(p_tx_valid), .tx_data(p_tx_data),
      .tx_err(p_tx_err), .lnk(u_pmp_if.phy));
   pmp_mac u_pmp_mac (.clk(clk), .resetn(resetn), .mode(mode),
      .speed(speed), .tx_valid(m_tx_valid), .tx_data(m_tx_data),
      .tx_err(m_tx_err), .tx_ready(m_tx_ready), .rx_valid(m_rx_valid),
      .rx_data(m_rx_data), .rx_err(m_rx_err), .crs_o(crs_o),
      .col_o(col_o), .lnk(u_pmp_if.mac));
   pmp_chk u_pmp_chk (.clk(clk), .resetn(resetn),
      .rx_clk(u_pmp_if.rx_clk), .rxd_lo(u_pmp_if.rxd_lo),
      .rxd_hi(u_pmp_if.rxd_hi), .rx_er_ctl(u_pmp_if.rx_er_ctl),
      .rx_dv(u_pmp_if.rx_dv), .mii_tx_clk(u_pmp_if.mii_tx_clk),
      .gtx_clk(u_pmp_if.gtx_clk), .txd_lo(u_pmp_if.txd_lo),
      .txd_hi(u_pmp_if.txd_hi), .tx_er_ctl(u_pmp_if.tx_er_ctl),
      .tx_en(u_pmp_if.tx_en));

   always #50 clk = ~clk;

   // ==========================================
   // Tasks
   task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp

   task final_report;
      $display("checks=%0d errors=%0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : final_report

   // Mode only changes under reset, so both ends switch together
   task automatic do_reset(input int m, input int s);
      @(negedge clk);
      resetn = 1'b0;
      mode   = pmp_pkg::pmp_mode_t'(m);
      speed  = pmp_pkg::pmp_speed_t'(s);
      repeat (8) @(negedge clk);
      resetn = 1'b1;
   endtask : do_reset

   // Holds each word until taken; notes the expectation at handover
   task automatic burst(input bit mac_side, input int n);
      logic [8:0] w;
      for (int i = 0; i < n; i++)
      begin
         w = 9'($urandom);
         if (mac_side)
         begin
            {m_tx_err, m_tx_data} = w;
            m_tx_valid = 1'b1;
            while (m_tx_ready !== 1'b1) @(negedge clk);
            txq.push_back(w);
         end
         else
         begin
            {med_err, med_data} = w;
            med_valid = 1'b1;
            while (med_ready !== 1'b1)
            begin
               stalls++;
               @(negedge clk);
            end
            rxq.push_back(w);
         end
         @(negedge clk);
      end
      if (mac_side)
         m_tx_valid = 1'b0;
      else
         med_valid = 1'b0;
   endtask : burst

   // ==========================================
   // Result watcher; mid-cycle, so registered pulses have settled
   always @(negedge clk)
   begin
      if (m_rx_valid === 1'b1)
         cmp({m_rx_err, m_rx_data},
             rxq.size() ? rxq.pop_front() : {9{1'bx}});
      if (p_tx_valid === 1'b1)
         cmp({p_tx_err, p_tx_data},
             txq.size() ? txq.pop_front() : {9{1'bx}});
   end

   // ==========================================
   // Main sequence
   initial
   begin
      clk = 1'b0; resetn = 1'b0; full_dup = 1'b0; link_up = 1'b1;
      carrier = 1'b0; collision = 1'b0; med_valid = 1'b0; med_err = 1'b0;
      med_data = 8'h00; m_tx_valid = 1'b0; m_tx_err = 1'b0;
      m_tx_data = 8'h00; mode = pmp_pkg::PMP_GMII;
      speed = pmp_pkg::PMP_S1000;
      void'($urandom(69));
      do_reset(0, 2);
      // Legal pairs of mode and speed, checked while held in reset
      @(negedge clk);
      resetn = 1'b0;
      carrier = 1'b1;
      collision = 1'b1;
      for (int m = 0; m < 4; m++)
         for (int s = 0; s < 4; s++)
         begin
            mode = pmp_pkg::pmp_mode_t'(m);
            speed = pmp_pkg::pmp_speed_t'(s);
            @(posedge clk);
            cmp({8'h00, cfg_ok}, 9'((m == 0 && s == 2) || (m == 1 && s < 2)
                || (m == 2 && s < 3)));
            @(negedge clk);
         end
      // Link down out of reset: bytes offered and carrier up, pins quiet
      link_up = 1'b0;
      do_reset(0, 2);
      med_valid = 1'b1;
      repeat (20) @(negedge clk);
      cmp({6'h00, cfg_ok, u_pmp_if.crs, u_pmp_if.col}, 9'h000);
      cmp({8'h00, u_pmp_if.rx_dv}, 9'h000);
      med_valid = 1'b0;
      link_up = 1'b1;
      carrier = 1'b0;
      collision = 1'b0;
      // Traffic both ways in every legal pairing
      for (int c = 0; c < 6; c++)
      begin
         do_reset(c < 3 ? (c == 0 ? 0 : 1) : 2,
                  c == 0 || c == 3 ? 2 : (c == 1 || c == 4 ? 1 : 0));
         fork
            burst(1'b0, 6);
            burst(1'b1, 6);
         join
         for (int k = 0; k < 4000 && (rxq.size() || txq.size()); k++)
            @(negedge clk);
         cmp(9'(rxq.size() + txq.size()), 9'h000);
      end
      cmp(9'(stalls > 0), 9'h001);
      // Carrier and collision in half, then full duplex
      do_reset(0, 2);
      carrier = 1'b1;
      collision = 1'b1;
      repeat (8) @(negedge clk);
      cmp({7'h00, crs_o, col_o}, 9'h003);
      full_dup = 1'b1;
      repeat (8) @(negedge clk);
      cmp({7'h00, crs_o, col_o}, 9'h000);
      final_report();
   end

   // Whole run is near 9000 cycles; over six times that means a hang
   initial
   begin
      repeat (60000) @(posedge clk);
      fail_count++;
      final_report();
   end
endmodule : tb
